// File: design/sps_pkg.sv
// Purpose: shared constants and types for the sensor power/reset sequencer
// Assumes: one 20 MHz clock for both ends, synchronous active-high reset
// Notes:   rails are one-bit enables, 1 = rail on; the link is pins only
//
// Behaviour
// RQ1 - host enables rails in order, 100 us apart
// RQ2 - pll rail never raised after others
// RQ3 - reference clock starts after last rail stable
// RQ4 - host holds hard reset low at least 1 ms
// RQ5 - pixel outputs tri-stated while hard reset asserted
// RQ6 - device init within 150000 clocks; host waits
// RQ7 - host configures, then waits 1 ms for lock
// RQ8 - stream bit one moves standby into streaming
// RQ9 - host clears stream bit first at power-down
// RQ10 - device finishes row or frame before standby
// RQ11 - host removes rails in reverse order, pll last
// RQ12 - host waits 100 ms before next power-up
// RQ13 - host walks explicit states, skipping no wait
package sps_pkg;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned RAIL_STEP_US   = 100;
  localparam int unsigned HARD_RESET_US  = 1000;
  localparam int unsigned PLL_LOCK_US    = 1000;
  localparam int unsigned OFF_WAIT_MS    = 100;
  localparam int unsigned INIT_REF_CLKS  = 150000;
  // least times round up to whole cycles
  localparam int unsigned RAIL_STEP_CYC  =
    (RAIL_STEP_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned HARD_RESET_CYC =
    (HARD_RESET_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned PLL_LOCK_CYC   =
    (PLL_LOCK_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned OFF_WAIT_CYC   = OFF_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned REF_DIV        = 2;
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned STREAM_BIT     = 2;
  localparam logic [15:0] RESET_CTRL_RST = 16'h0000;

  // rail index in power-up order
  localparam int unsigned RAIL_PLL  = 0;
  localparam int unsigned RAIL_ANA  = 1;
  localparam int unsigned RAIL_IO   = 2;
  localparam int unsigned RAIL_CORE = 3;
  localparam int unsigned RAIL_SER  = 4;
  localparam int unsigned RAIL_N    = 5;

  typedef enum logic [3:0] {
    SPS_H_OFF    = 4'h0,
    SPS_H_RAILS  = 4'h1,
    SPS_H_CLOCK  = 4'h2,
    SPS_H_RESET  = 4'h3,
    SPS_H_INIT   = 4'h4,
    SPS_H_CONFIG = 4'h5,
    SPS_H_LOCK   = 4'h6,
    SPS_H_STREAM = 4'h7,
    SPS_H_DRAIN  = 4'h8,
    SPS_H_DOWN   = 4'h9,
    SPS_H_REST   = 4'ha
  } sps_host_state_t;

  typedef enum logic [2:0] {
    SPS_D_UNPWR   = 3'h0,
    SPS_D_RESET   = 3'h1,
    SPS_D_INIT    = 3'h2,
    SPS_D_STANDBY = 3'h3,
    SPS_D_STREAM  = 3'h4,
    SPS_D_DRAIN   = 3'h5
  } sps_dev_state_t;
endpackage

// File: design/sps_link_if.sv
`timescale 1ns/10ps
// Purpose: pin-level link between host sequencer and sensor
// Assumes: all signals synchronous to the common clk
// Notes:   the stream bit stands in for the reset control register bit
interface sps_link_if;
  logic [4:0] rail_en;
  logic       reference_clock_in;
  logic       hard_reset_n;
  logic       stream_bit;
  logic       standby;
  logic       streaming;

  modport host (
    output rail_en,
    output reference_clock_in,
    output hard_reset_n,
    output stream_bit,
    input  standby,
    input  streaming
  );
  modport dev (
    input  rail_en,
    input  reference_clock_in,
    input  hard_reset_n,
    input  stream_bit,
    output standby,
    output streaming
  );
endinterface

// File: design/sps_host.sv
`timescale 1ns/10ps
// Purpose: host power, clock, reset and streaming sequencer
// Assumes: single clock; start/stop are level requests from the user
// Notes:   configuration is the user's job, signalled by cfg_done
module sps_host #(
  parameter int unsigned RAIL_STEP_CYC  = sps_pkg::RAIL_STEP_CYC,
  parameter int unsigned HARD_RESET_CYC = sps_pkg::HARD_RESET_CYC,
  parameter int unsigned INIT_REF_CLKS  = sps_pkg::INIT_REF_CLKS,
  parameter int unsigned PLL_LOCK_CYC   = sps_pkg::PLL_LOCK_CYC,
  parameter int unsigned OFF_WAIT_CYC   = sps_pkg::OFF_WAIT_CYC
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // link
  sps_link_if.host                      link,
  // user side
  input  wire logic                     power_req,
  input  wire logic                     cfg_done,
  output logic                          cfg_window,
  output sps_pkg::sps_host_state_t      state
);
  import sps_pkg::*;

  sps_host_state_t   state_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [2:0]        rail_idx_reg;
  logic [RAIL_N-1:0] rail_reg;
  logic              ref_en_reg;
  logic              ref_clk_reg;
  logic [CNT_W-1:0]  ref_cnt_reg;
  logic              rst_n_reg;
  logic              stream_reg;
  logic              ref_rise;
  logic              hold_cnt;
  logic              start;
  logic              rail_tick;
  logic              rails_up;
  logic              reset_done;
  logic              init_done;
  logic              cfg_taken;
  logic              lock_done;
  logic              stop_req;
  logic              drained;
  logic              down_tick;
  logic              rails_off;
  logic              rest_done;

  function automatic logic done(input logic [CNT_W-1:0] c,
                                input int unsigned n);
    done = (c >= CNT_W'(n - 1));
  endfunction

  assign ref_rise = ref_en_reg && !ref_clk_reg;

  // step events, one per wait, two in RAILS and DOWN; init_done, cfg_taken, rails_off and rest_done drive only the state
  assign start      = (state_reg == SPS_H_OFF) && power_req;
  assign rail_tick  = (state_reg == SPS_H_RAILS) &&
                      done(cnt_reg, RAIL_STEP_CYC); // RQ1
  assign rails_up   = rail_tick && (rail_idx_reg == 3'(RAIL_N));
  assign reset_done = (state_reg == SPS_H_RESET) &&
                      done(cnt_reg, HARD_RESET_CYC); // RQ4
  assign init_done  = (state_reg == SPS_H_INIT) && ref_rise &&
                      done(ref_cnt_reg, INIT_REF_CLKS); // RQ6
  assign cfg_taken  = (state_reg == SPS_H_CONFIG) && cfg_done; // RQ7
  assign lock_done  = (state_reg == SPS_H_LOCK) &&
                      done(cnt_reg, PLL_LOCK_CYC); // RQ7
  assign stop_req   = (state_reg == SPS_H_STREAM) && !power_req; // RQ9
  // soft standby reported by the device ends the drain
  assign drained    = (state_reg == SPS_H_DRAIN) && link.standby &&
                      !link.streaming; // RQ10
  assign down_tick  = (state_reg == SPS_H_DOWN) &&
                      done(cnt_reg, RAIL_STEP_CYC); // RQ11
  assign rails_off  = down_tick && (rail_idx_reg == 3'h1);
  assign rest_done  = (state_reg == SPS_H_REST) &&
                      done(cnt_reg, OFF_WAIT_CYC); // RQ12
  // the step counter idles at zero in states that wait on events
  assign hold_cnt   = (state_reg == SPS_H_OFF)    ||
                      (state_reg == SPS_H_CLOCK)  ||
                      (state_reg == SPS_H_INIT)   ||
                      (state_reg == SPS_H_CONFIG) ||
                      (state_reg == SPS_H_STREAM) ||
                      (state_reg == SPS_H_DRAIN);

  // sequence state; every wait ends only on its own step event
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= SPS_H_OFF;
    end else begin
      unique case (state_reg)
        SPS_H_OFF: begin
          if (start) begin
            state_reg <= SPS_H_RAILS;
          end
        end
        SPS_H_RAILS: begin
          if (rails_up) begin
            state_reg <= SPS_H_CLOCK; // RQ13
          end
        end
        SPS_H_CLOCK: begin
          // clock starts on entry; reset width counted from SPS_H_RESET entry
          state_reg <= SPS_H_RESET; // RQ3
        end
        SPS_H_RESET: begin
          if (reset_done) begin
            state_reg <= SPS_H_INIT;
          end
        end
        SPS_H_INIT: begin
          if (init_done) begin
            state_reg <= SPS_H_CONFIG;
          end
        end
        SPS_H_CONFIG: begin
          if (cfg_taken) begin
            state_reg <= SPS_H_LOCK;
          end
        end
        SPS_H_LOCK: begin
          if (lock_done) begin
            state_reg <= SPS_H_STREAM;
          end
        end
        SPS_H_STREAM: begin
          if (stop_req) begin
            state_reg <= SPS_H_DRAIN;
          end
        end
        SPS_H_DRAIN: begin
          if (drained) begin
            state_reg <= SPS_H_DOWN;
          end
        end
        SPS_H_DOWN: begin
          if (rails_off) begin
            state_reg <= SPS_H_REST;
          end
        end
        SPS_H_REST: begin
          if (rest_done) begin
            state_reg <= SPS_H_OFF;
          end
        end
        default: begin
          state_reg <= SPS_H_OFF; // RQ13
        end
      endcase
    end
  end

  // one shared step counter: the timed waits never overlap
  always_ff @(posedge clk) begin
    if (rst || hold_cnt || rail_tick || down_tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // rails rise in order and fall in reverse, one per step
  always_ff @(posedge clk) begin
    if (rst) begin
      rail_reg     <= '0;
      rail_idx_reg <= '0;
    end else if (start) begin
      rail_reg[RAIL_PLL] <= 1'b1; // RQ2
      rail_idx_reg       <= 3'h1;
    end else if (rail_tick && !rails_up) begin
      rail_reg[rail_idx_reg] <= 1'b1; // RQ1
      rail_idx_reg           <= rail_idx_reg + 3'h1;
    end else if (drained) begin
      rail_idx_reg <= 3'(RAIL_N);
    end else if (down_tick) begin
      rail_reg[rail_idx_reg - 3'h1] <= 1'b0; // RQ11
      rail_idx_reg                  <= rail_idx_reg - 3'h1;
    end
  end

  // clock runs only once every rail is up, and stops before rails fall
  always_ff @(posedge clk) begin
    if (rst || drained) begin
      ref_en_reg <= 1'b0;
    end else if (rails_up) begin
      ref_en_reg <= 1'b1; // RQ3
    end
  end

  // reference clock: divided from clk, only once rails are stable
  always_ff @(posedge clk) begin
    if (rst || !ref_en_reg) begin
      ref_clk_reg <= 1'b0;
    end else begin
      ref_clk_reg <= ~ref_clk_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || reset_done) begin
      ref_cnt_reg <= '0;
    end else if ((state_reg == SPS_H_INIT) && ref_rise) begin
      ref_cnt_reg <= ref_cnt_reg + 1'b1; // RQ6
    end
  end

  // hard reset low for the whole width and again at power-down
  always_ff @(posedge clk) begin
    if (rst || drained) begin
      rst_n_reg <= 1'b0;
    end else if (reset_done) begin
      rst_n_reg <= 1'b1; // RQ4
    end
  end

  always_ff @(posedge clk) begin
    if (rst || stop_req) begin
      stream_reg <= 1'b0; // RQ9
    end else if (lock_done) begin
      stream_reg <= 1'b1; // RQ8
    end
  end

  assign link.rail_en            = rail_reg;
  assign link.reference_clock_in = ref_clk_reg;
  assign link.hard_reset_n       = rst_n_reg;
  assign link.stream_bit         = stream_reg;
  assign cfg_window              = (state_reg == SPS_H_CONFIG);
  assign state                   = state_reg;
endmodule

// File: design/sps_dev.sv
`timescale 1ns/10ps
// Purpose: sensor-side reset, init, standby and streaming control
// Assumes: reference clock sampled on clk, clk at least twice its rate
// Notes:   row/frame ends come from the readout as one-cycle pulses
module sps_dev #(
  parameter int unsigned INIT_REF_CLKS = sps_pkg::INIT_REF_CLKS,
  parameter int unsigned PIX_W         = 12
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // link
  sps_link_if.dev                      link,
  // readout side
  input  wire logic                    stop_at_frame,
  input  wire logic                    row_end,
  input  wire logic                    frame_end,
  input  wire logic [PIX_W-1:0]        pix_in,
  output logic [PIX_W-1:0]             pix_out,
  output logic                         pix_oe,
  output sps_pkg::sps_dev_state_t      state
);
  import sps_pkg::*;

  sps_dev_state_t   state_reg;
  logic [CNT_W-1:0] init_cnt_reg;
  logic             ref_d_reg;
  logic [PIX_W-1:0] pix_reg;
  logic             powered;
  logic             ref_rise;

  assign powered  = &link.rail_en;
  assign ref_rise = link.reference_clock_in && !ref_d_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_d_reg <= 1'b0;
    end else begin
      ref_d_reg <= link.reference_clock_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !powered) begin
      state_reg    <= SPS_D_UNPWR;
      init_cnt_reg <= '0;
    end else if (!link.hard_reset_n) begin
      state_reg    <= SPS_D_RESET;
      init_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        SPS_D_UNPWR, SPS_D_RESET: begin
          state_reg <= SPS_D_INIT;
        end
        SPS_D_INIT: begin
          // counted to one rise fewer than the host waits, so standby comes one clk early
          if (ref_rise) begin
            init_cnt_reg <= init_cnt_reg + 1'b1;
            if (init_cnt_reg >= CNT_W'(INIT_REF_CLKS - 2)) begin // RQ6
              state_reg <= SPS_D_STANDBY;
            end
          end
        end
        SPS_D_STANDBY: begin
          if (link.stream_bit) begin
            state_reg <= SPS_D_STREAM; // RQ8
          end
        end
        SPS_D_STREAM: begin
          if (!link.stream_bit) begin
            state_reg <= SPS_D_DRAIN;
          end
        end
        SPS_D_DRAIN: begin
          if (stop_at_frame ? frame_end : row_end) begin // RQ10
            state_reg <= SPS_D_STANDBY;
          end
        end
        default: begin
          state_reg <= SPS_D_UNPWR;
        end
      endcase
    end
  end

  // pixel data registered; enable gated off while in hard reset
  always_ff @(posedge clk) begin
    if (rst) begin
      pix_reg <= '0;
    end else begin
      pix_reg <= pix_in;
    end
  end

  assign pix_oe         = link.hard_reset_n && powered &&
                          (state_reg != SPS_D_RESET); // RQ5
  assign pix_out        = pix_reg;
  assign link.standby   = (state_reg == SPS_D_STANDBY);
  assign link.streaming = (state_reg == SPS_D_STREAM) ||
                          (state_reg == SPS_D_DRAIN);
  assign state          = state_reg;
endmodule

// File: verification/sps_link_properties.sv
// Purpose: assertions on the host-sensor link pins
// Assumes: counts shortened as in the bench
// Notes:   sees the link signals only
`timescale 1ns/10ps
module sps_link_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // link
  input wire logic [4:0] rail_en,
  input wire logic       reference_clock_in,
  input wire logic       hard_reset_n,
  input wire logic       stream_bit,
  input wire logic       standby,
  input wire logic       streaming
);
  logic [7:0] low_reg;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // reset-low time with all rails up; saturates so it never wraps
  always_ff @(posedge clk) begin
    if (rst || hard_reset_n || rail_en != 5'h1f) begin
      low_reg <= 8'h00;
    end else if (low_reg != 8'hff) begin
      low_reg <= low_reg + 8'h01;
    end
  end
  sequence s_off8;
    rail_en == 5'h00 [*8];
  endsequence
  property p_order; ((rail_en + 5'h01) & rail_en) == 5'h00; endproperty
  a_order: assert property (p_order) else $error("rail order");
  property p_step; $changed(rail_en) |=> $stable(rail_en) [*3]; endproperty
  a_step: assert property (p_step) else $error("rail step");
  property p_clk;
    reference_clock_in |-> rail_en == 5'h1f && $past(rail_en, 3) == 5'h1f;
  endproperty
  a_clk: assert property (p_clk) else $error("early clock");
  property p_rstw; $rose(hard_reset_n) |-> low_reg >= 8'h08; endproperty
  a_rstw: assert property (p_rstw) else $error("short reset");
  property p_init;
    $rose(hard_reset_n) |-> !standby [*8] ##[1:16] standby;
  endproperty
  a_init: assert property (p_init) else $error("init time");
  property p_go; standby && stream_bit |=> streaming && !standby; endproperty
  a_go: assert property (p_go) else $error("no stream");
  property p_stop; $fell(rail_en[4]) |-> !stream_bit && !streaming; endproperty
  a_stop: assert property (p_stop) else $error("live off");
  property p_rest; $fell(rail_en[0]) |-> s_off8 ##1 s_off8; endproperty
  a_rest: assert property (p_rest) else $error("short rest");
endmodule

// File: verification/sensor_power_reset_sequencer_test.sv
// Purpose: end-to-end check of host and sensor sequencing
// Assumes: shortened step counts but the full lock wait, 50 ns clock
// Notes:   inputs change on the falling edge only
`timescale 1ns/10ps
module sensor_power_reset_sequencer_test;
  import sps_pkg::*;
  logic            clk;
  logic            rst;
  logic            power_req;
  logic            cfg_done;
  logic            cfg_window;
  logic            stop_at_frame;
  logic            row_end;
  logic            frame_end;
  logic [11:0]     pix_in;
  logic [11:0]     pix_out;
  logic            pix_oe;
  sps_host_state_t hs;
  sps_dev_state_t  ds;
  int              errors;
  int              cmp_count;
  sps_link_if link ();
  sps_host #(.RAIL_STEP_CYC(4), .HARD_RESET_CYC(8), .INIT_REF_CLKS(10),
    .OFF_WAIT_CYC(16)) i_sps_host (.clk(clk), .rst(rst),
    .link(link), .power_req(power_req), .cfg_done(cfg_done),
    .cfg_window(cfg_window), .state(hs));
  sps_dev #(.INIT_REF_CLKS(10)) i_sps_dev (.clk(clk),
    .rst(rst), .link(link), .stop_at_frame(stop_at_frame),
    .row_end(row_end), .frame_end(frame_end), .pix_in(pix_in),
    .pix_out(pix_out), .pix_oe(pix_oe), .state(ds));
  sps_link_properties i_props (.clk(clk), .rst(rst),
    .rail_en(link.rail_en), .reference_clock_in(link.reference_clock_in),
    .hard_reset_n(link.hard_reset_n), .stream_bit(link.stream_bit),
    .standby(link.standby), .streaming(link.streaming));
  always #25 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded, so a stuck host shows as a mismatch instead of a hang
  task automatic wait_hs(input sps_host_state_t s);
    int n = 0;
    while (hs !== s && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(16'(hs), 16'(s));
  endtask
  task automatic pulse(input logic fr);
    row_end = !fr;
    frame_end = fr;
    @(negedge clk);
    row_end = 1'h0;
    frame_end = 1'h0;
  endtask
  task automatic results;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // two passes of about 20100 cycles each, mostly the lock wait
  initial begin
    #2500000;
    errors++;
    results();
  end
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    power_req = 1'h0;
    cfg_done = 1'h0;
    stop_at_frame = 1'h0;
    row_end = 1'h0;
    frame_end = 1'h0;
    pix_in = 12'h000;
    errors = 0;
    cmp_count = 0;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    // second pass powers up again while the host still rests
    for (int m = 0; m < 2; m++) begin
      stop_at_frame = m[0];
      power_req = 1'h1;
      wait_hs(SPS_H_RESET);
      chk(16'(pix_oe), 16'h0);
      chk(16'(link.rail_en), 16'h1f);
      wait_hs(SPS_H_CONFIG);
      chk(16'(link.standby), 16'h1);
      chk(16'(cfg_window), 16'h1);
      chk(16'(pix_oe), 16'h1);
      pix_in = 12'ha5c;
      @(negedge clk);
      chk(16'(pix_out), 16'ha5c);
      cfg_done = 1'h1;
      wait_hs(SPS_H_LOCK);
      cfg_done = 1'h0;
      repeat (PLL_LOCK_CYC - 2) @(negedge clk);
      chk(16'(link.stream_bit), 16'h0);
      wait_hs(SPS_H_STREAM);
      repeat (2) @(negedge clk);
      chk(16'(ds), 16'(SPS_D_STREAM));
      power_req = 1'h0;
      repeat (3) @(negedge clk);
      chk(16'(link.stream_bit), 16'h0);
      chk(16'(link.streaming), 16'h1);
      pulse(1'h0);
      chk(16'(link.streaming), 16'(m));
      if (m == 1) begin
        pulse(1'h1);
        chk(16'(link.standby), 16'h1);
      end
      wait_hs(SPS_H_REST);
      chk(16'(link.rail_en), 16'h00);
    end
    power_req = 1'h0;
    wait_hs(SPS_H_OFF);
    chk(16'(link.hard_reset_n), 16'h0);
    results();
  end
endmodule
